// ### hdl/tpec_top.sv
// two-task stored program execution controller with an AXI4-Lite slave
//
// Notes on behaviour
// - cycle start rise starts program from the top or resumes interrupted block
// - each block beginning samples cycle start: high continues, low stops
// - block after a pass block runs even with start low, then program stops
// - after an error is cleared, cycle start continues the program
// - task 2 has identical control bits in its own word
// - single block set: each cycle start runs one block then pauses
// - single block sampled at start rise and at each block beginning
// - single cleared plus cycle start resumes continuously at next block
// - single during pass finishes next block positioning before pausing
// - forced end rise aborts block, decelerates; restart at next block
// - forced end during aux wait clears code and strobe, then stops
// - forced end held high blocks cycle start
// - forced end wins over pause when both rise together
// - pause rise interrupts block, decelerates; restart same block
// - pause held high blocks cycle start
// - aux code 0 to 499 holds block waiting for aux reset
// - aux reset rise clears code and strobe; fall resumes execution
// - aux reset already high suppresses block's aux code output
// - codes 500 to 999 never hold; aux reset rise clears them any mode
// - mode bit high is automatic, low manual; only automatic runs
`timescale 1ns/1ps
`default_nettype none
`include "tpec_map.svh"

module tpec_top (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // axi4-lite write address
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    // axi4-lite write data
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    // axi4-lite write response
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    // axi4-lite read address
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    // axi4-lite read data
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    // per-task status to the motion side
    output logic [1:0] TASK_RUN,
    output logic [1:0] AXIS_MOVE,
    output logic [1:0] AXIS_DECEL,
    output logic [1:0] AUX_STROBE
);
    import tpec_pkg::*;

    localparam logic [7:0] PROC_DIV = 8'(`TPEC_PROC_DIV);

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] stb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (stb[i]) begin
                res[8*i +: 8] = dat[8*i +: 8];
            end
        end
        return res;
    endfunction : merge

    // control bits of a host word, same positions for both tasks
    function automatic tpec_ctl_t ctl_of(input logic [31:0] w);
        tpec_ctl_t c;
        c.auto_m = w[`TPEC_BIT_AUTO];
        c.start = w[`TPEC_BIT_START];
        c.single = w[`TPEC_BIT_SINGLE];
        c.fbe = w[`TPEC_BIT_FBE];
        c.pause = w[`TPEC_BIT_PAUSE];
        c.auxrst = w[`TPEC_BIT_AUXRST];
        return c;
    endfunction : ctl_of

    // bus state
    logic aw_have_reg, w_have_reg, bvalid_reg, awready_reg, wready_reg;
    logic arready_reg, rvalid_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;

    // host words, program store and per-task state
    logic [31:0] ctrl_reg [2];
    logic [31:0] prog_mem [32];
    tpec_state_t st_reg [2], st_next [2];
    tpec_ctl_t old_reg [2], old_next [2];
    logic [3:0] blk_reg [2], blk_next [2];
    logic [7:0] timer_reg [2], timer_next [2];
    logic [9:0] aux_reg [2], aux_next [2];
    logic [1:0] strobe_reg, strobe_next, err_reg, err_next;
    logic [1:0] single_reg, single_next, stop_reg, stop_next;
    logic [1:0] pass_reg, pass_next, done_reg, done_next;
    logic [7:0] div_reg;
    logic tick_reg;

    // write and read decode
    wire wr_go = aw_have_reg & w_have_reg & ~bvalid_reg;
    wire [1:0] wr_win = awaddr_reg[7:6];
    wire wr_ctrl0 = awaddr_reg == `TPEC_OFF_CTRL0;
    wire wr_ctrl1 = awaddr_reg == `TPEC_OFF_CTRL1;
    wire wr_errc = awaddr_reg == `TPEC_OFF_ERRCLR;
    wire wr_prog = wr_win == `TPEC_OFF_PROG0 || wr_win == `TPEC_OFF_PROG1;
    wire wr_stat = awaddr_reg == `TPEC_OFF_STAT0 ||
        awaddr_reg == `TPEC_OFF_STAT1;
    wire wr_hit = wr_ctrl0 | wr_ctrl1 | wr_errc | wr_prog | wr_stat;
    wire [4:0] wr_idx = {wr_win == `TPEC_OFF_PROG1, awaddr_reg[5:2]};
    wire [1:0] err_clr = (wr_go & wr_errc) ?
        (wdata_reg[1:0] & {2{wstrb_reg[0]}}) : 2'h0;
    wire ar_take = S_AXI_ARVALID & arready_reg;
    wire [1:0] rd_win = S_AXI_ARADDR[7:6];
    wire rd_prog = rd_win == `TPEC_OFF_PROG0 || rd_win == `TPEC_OFF_PROG1;
    wire [4:0] rd_idx = {rd_win == `TPEC_OFF_PROG1, S_AXI_ARADDR[5:2]};
    tpec_stat_t stat_w [2];
    logic [31:0] rd_data;
    logic rd_hit;

    // status words show each task's own state
    for (genvar g = 0; g < 2; g++) begin : g_stat
        assign stat_w[g] = '{rsv_hi: 6'h00, aux: aux_reg[g],
            rsv_mid: 4'h0, blk: blk_reg[g], rsv_lo: 3'h0,
            done: done_reg[g], err: err_reg[g],
            aux_wait: st_reg[g] == ST_AUXWAIT,
            strobe: strobe_reg[g], run: st_reg[g] != ST_IDLE};
    end

    // read mux
    assign rd_hit = rd_prog || S_AXI_ARADDR == `TPEC_OFF_CTRL0 ||
        S_AXI_ARADDR == `TPEC_OFF_CTRL1 ||
        S_AXI_ARADDR == `TPEC_OFF_STAT0 ||
        S_AXI_ARADDR == `TPEC_OFF_STAT1 ||
        S_AXI_ARADDR == `TPEC_OFF_ERRCLR;
    assign rd_data = rd_prog ? {8'h00, prog_mem[rd_idx][23:0]} :
        S_AXI_ARADDR == `TPEC_OFF_CTRL0 ? ctrl_reg[0] :
        S_AXI_ARADDR == `TPEC_OFF_CTRL1 ? ctrl_reg[1] :
        S_AXI_ARADDR == `TPEC_OFF_STAT0 ? 32'(stat_w[0]) :
        S_AXI_ARADDR == `TPEC_OFF_STAT1 ? 32'(stat_w[1]) :
        S_AXI_ARADDR == `TPEC_OFF_ERRCLR ? {30'h0, err_reg} : 32'h0;

    // processing cycle enable
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            div_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= div_reg == PROC_DIV - 8'h01;
            div_reg <= (div_reg == PROC_DIV - 8'h01) ? 8'h00 :
                div_reg + 8'h01;
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `TPEC_RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && awready_reg) begin
                aw_have_reg <= 1'b1;
                awready_reg <= 1'b0;
                awaddr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && wready_reg) begin
                w_have_reg <= 1'b1;
                wready_reg <= 1'b0;
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? `TPEC_RESP_OKAY : `TPEC_RESP_SLVERR;
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
            end
            if (bvalid_reg && S_AXI_BREADY) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // host-written task words, program store in the next block
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_reg[0] <= `TPEC_RST_CTRL;
            ctrl_reg[1] <= `TPEC_RST_CTRL;
        end else if (wr_go) begin
            if (wr_ctrl0) ctrl_reg[0] <= merge(ctrl_reg[0], wdata_reg,
                wstrb_reg);
            if (wr_ctrl1) ctrl_reg[1] <= merge(ctrl_reg[1], wdata_reg,
                wstrb_reg);
        end
    end

    // program memory holds no reset
    always_ff @(posedge REF_CLK) begin
        if (wr_go && wr_prog) begin
            prog_mem[wr_idx] <= merge(prog_mem[wr_idx], wdata_reg,
                wstrb_reg);
        end
    end

    // read channel
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `TPEC_RESP_OKAY;
        end else if (ar_take) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_data;
            rresp_reg <= rd_hit ? `TPEC_RESP_OKAY : `TPEC_RESP_SLVERR;
        end else if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // per-task sequencer, both tasks share one description
    always_comb begin
        tpec_ctl_t c, r, f;
        tpec_blk_t e;
        logic run, fin;
        c = '0;
        r = '0;
        f = '0;
        e = '0;
        run = 1'b0;
        fin = 1'b0;
        strobe_next = strobe_reg;
        single_next = single_reg;
        stop_next = stop_reg;
        pass_next = pass_reg;
        done_next = done_reg;
        err_next = err_reg & ~err_clr;
        for (int t = 0; t < 2; t++) begin
            st_next[t] = st_reg[t];
            old_next[t] = old_reg[t];
            blk_next[t] = blk_reg[t];
            timer_next[t] = timer_reg[t];
            aux_next[t] = aux_reg[t];
            fin = 1'b0;
            c = ctl_of(ctrl_reg[t]);
            r = c & ~old_reg[t];
            f = ~c & old_reg[t];
            e = tpec_blk_t'(prog_mem[{t[0], blk_reg[t]}][23:0]);
            run = st_reg[t] == ST_BEGIN || st_reg[t] == ST_EXEC ||
                st_reg[t] == ST_AUXWAIT;
            if (tick_reg) begin
                old_next[t] = c;
                // upper codes clear on reset rise in either mode
                if (r.auxrst && strobe_reg[t] &&
                    aux_reg[t] > `TPEC_AUX_HOLD_MAX) begin
                    aux_next[t] = `TPEC_RST_AUX;
                    strobe_next[t] = 1'b0;
                end
                if (run && !c.auto_m) begin
                    st_next[t] = ST_DECEL;
                    timer_next[t] = `TPEC_DECEL_TICKS;
                end else if (run && r.fbe) begin
                    if (st_reg[t] == ST_AUXWAIT) begin
                        aux_next[t] = `TPEC_RST_AUX;
                        strobe_next[t] = 1'b0;
                    end
                    done_next[t] = e.last;
                    blk_next[t] = e.last ? 4'h0 : blk_reg[t] + 4'h1;
                    st_next[t] = ST_DECEL;
                    timer_next[t] = `TPEC_DECEL_TICKS;
                end else if (run && r.pause) begin
                    st_next[t] = ST_DECEL;
                    timer_next[t] = `TPEC_DECEL_TICKS;
                end else begin
                    case (st_reg[t])
                        ST_IDLE: begin
                            if (c.auto_m && r.start && !c.fbe &&
                                !c.pause && !err_reg[t]) begin
                                single_next[t] = c.single;
                                stop_next[t] = 1'b0;
                                pass_next[t] = 1'b0;
                                done_next[t] = 1'b0;
                                if (done_reg[t]) blk_next[t] = 4'h0;
                                st_next[t] = ST_BEGIN;
                            end
                        end
                        ST_BEGIN: begin
                            if (!c.start && !pass_reg[t]) begin
                                st_next[t] = ST_IDLE;
                            end else begin
                                stop_next[t] = !c.start;
                                single_next[t] = c.single;
                                pass_next[t] = e.pass;
                                timer_next[t] = e.dur;
                                st_next[t] = ST_EXEC;
                            end
                        end
                        ST_EXEC: begin
                            if (timer_reg[t] != 8'h00) begin
                                timer_next[t] = timer_reg[t] - 8'h01;
                            end else if (!e.has_aux || c.auxrst) begin
                                fin = 1'b1;
                            end else if (e.aux > `TPEC_AUX_MAX) begin
                                err_next[t] = 1'b1;
                                st_next[t] = ST_IDLE;
                            end else begin
                                aux_next[t] = e.aux;
                                strobe_next[t] = 1'b1;
                                if (e.aux <= `TPEC_AUX_HOLD_MAX) begin
                                    st_next[t] = ST_AUXWAIT;
                                end else begin
                                    fin = 1'b1;
                                end
                            end
                        end
                        ST_AUXWAIT: begin
                            if (r.auxrst) begin
                                aux_next[t] = `TPEC_RST_AUX;
                                strobe_next[t] = 1'b0;
                            end else if (f.auxrst && !strobe_reg[t]) begin
                                fin = 1'b1;
                            end
                        end
                        ST_DECEL: begin
                            if (timer_reg[t] == 8'h00) begin
                                st_next[t] = ST_IDLE;
                            end else begin
                                timer_next[t] = timer_reg[t] - 8'h01;
                            end
                        end
                        default: st_next[t] = ST_IDLE;
                    endcase
                end
                // block complete: advance, then stop or go on
                if (fin) begin
                    done_next[t] = e.last;
                    blk_next[t] = e.last ? 4'h0 : blk_reg[t] + 4'h1;
                    if (e.last || stop_reg[t] || single_reg[t]) begin
                        st_next[t] = ST_IDLE;
                    end else begin
                        st_next[t] = ST_BEGIN;
                    end
                end
            end
        end
    end

    // per-task state registers
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int t = 0; t < 2; t++) begin
                st_reg[t] <= ST_IDLE;
                old_reg[t] <= '0;
                blk_reg[t] <= 4'h0;
                timer_reg[t] <= 8'h00;
                aux_reg[t] <= `TPEC_RST_AUX;
            end
            strobe_reg <= 2'h0;
            err_reg <= 2'h0;
            single_reg <= 2'h0;
            stop_reg <= 2'h0;
            pass_reg <= 2'h0;
            done_reg <= 2'h1;
        end else begin
            st_reg <= st_next;
            old_reg <= old_next;
            blk_reg <= blk_next;
            timer_reg <= timer_next;
            aux_reg <= aux_next;
            strobe_reg <= strobe_next;
            err_reg <= err_next;
            single_reg <= single_next;
            stop_reg <= stop_next;
            pass_reg <= pass_next;
            done_reg <= done_next;
        end
    end

    // motion-side outputs from flops
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            TASK_RUN <= 2'h0;
            AXIS_MOVE <= 2'h0;
            AXIS_DECEL <= 2'h0;
            AUX_STROBE <= 2'h0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                TASK_RUN[t] <= st_next[t] != ST_IDLE;
                AXIS_MOVE[t] <= st_next[t] == ST_EXEC;
                AXIS_DECEL[t] <= st_next[t] == ST_DECEL;
            end
            AUX_STROBE <= strobe_next;
        end
    end

    // bus outputs
    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;

endmodule : tpec_top

`default_nettype wire

// ### inc/tpec_map.svh
// register offsets, bit positions, reset values and timing counts
`ifndef TPEC_MAP_SVH
`define TPEC_MAP_SVH

// register byte offsets and program window codes
`define TPEC_OFF_CTRL0 8'h00
`define TPEC_OFF_CTRL1 8'h04
`define TPEC_OFF_STAT0 8'h08
`define TPEC_OFF_STAT1 8'h0c
`define TPEC_OFF_ERRCLR 8'h10
`define TPEC_OFF_PROG0 2'h1
`define TPEC_OFF_PROG1 2'h2

// control bit positions, same in both task words
`define TPEC_BIT_AUTO 1
`define TPEC_BIT_START 2
`define TPEC_BIT_SINGLE 3
`define TPEC_BIT_FBE 4
`define TPEC_BIT_PAUSE 5
`define TPEC_BIT_AUXRST 6

// reset values
`define TPEC_RST_CTRL 32'h0000_0000
`define TPEC_RST_AUX 10'h000

// auxiliary code ranges
`define TPEC_AUX_HOLD_MAX 10'd499
`define TPEC_AUX_MAX 10'd999

// timing
`define TPEC_CLK_PERIOD_NS 5
`define TPEC_PROC_PERIOD_NS 1000
`define TPEC_PROC_DIV (`TPEC_PROC_PERIOD_NS / `TPEC_CLK_PERIOD_NS)
`define TPEC_DECEL_TICKS 8'h08

// bus answers
`define TPEC_RESP_OKAY 2'h0
`define TPEC_RESP_SLVERR 2'h2

`endif

// ### inc/tpec_pkg.sv
// types shared by the program execution controller
`default_nettype none
package tpec_pkg;

    // sampled control bits of one task word
    typedef struct packed {
        logic auxrst;
        logic pause;
        logic fbe;
        logic single;
        logic start;
        logic auto_m;
    } tpec_ctl_t;

    // one stored program block, low 24 bits of a word
    typedef struct packed {
        logic [7:0] dur;
        logic [2:0] rsv;
        logic last;
        logic pass;
        logic has_aux;
        logic [9:0] aux;
    } tpec_blk_t;

    // status word of one task
    typedef struct packed {
        logic [5:0] rsv_hi;
        logic [9:0] aux;
        logic [3:0] rsv_mid;
        logic [3:0] blk;
        logic [2:0] rsv_lo;
        logic done;
        logic err;
        logic aux_wait;
        logic strobe;
        logic run;
    } tpec_stat_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BEGIN,
        ST_EXEC,
        ST_AUXWAIT,
        ST_DECEL
    } tpec_state_t;

endpackage : tpec_pkg
`default_nettype wire

// ### test/tpec_top_assertions.sv
// bus and task status checks bound to the execution controller
`timescale 1ns/1ps
`default_nettype none

module tpec_chk (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // bus handshakes
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA,
    // task status
    input wire logic [1:0] TASK_RUN,
    input wire logic [1:0] AXIS_MOVE,
    input wire logic [1:0] AXIS_DECEL
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    // write steps: both halves taken, then an answer left waiting
    sequence wr_both;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence b_wait;
        S_AXI_BVALID && !S_AXI_BREADY;
    endsequence
    wr_answer_a: assert property (wr_both |=> ##1 S_AXI_BVALID)
        else $error("write answer late");
    b_hold_a: assert property (b_wait |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write answer dropped");
    wr_refuse_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while answer pending");
    rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        |=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("read answer late");
    r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data moved");
    move_run_a: assert property ((AXIS_MOVE & ~TASK_RUN) == 2'h0)
        else $error("axes move without a running program");
    decel_run_a: assert property ((AXIS_DECEL & ~TASK_RUN) == 2'h0)
        else $error("deceleration outside a run");
    move_decel_a: assert property ((AXIS_MOVE & AXIS_DECEL) == 2'h0)
        else $error("block moves while decelerating");
endmodule : tpec_chk

bind tpec_top tpec_chk chk (.REF_CLK, .ARST_N, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY,
    .S_AXI_RDATA, .TASK_RUN, .AXIS_MOVE, .AXIS_DECEL);
`default_nettype wire

// ### test/tpec_host.sv
// host controller model writing and reading the interface words
`timescale 1ns/1ps
`default_nettype none

module tpec_host (
    // clock
    input wire logic clk,
    // write channels
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    // read channels
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    // bus idle from time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
        {awaddr, araddr, wdata} <= 48'h0;
    end
    // address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            output logic [1:0] r);
        logic [1:0] t;
        t = 2'h0;
        {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
        while (t != 2'h3) begin
            @(posedge clk);
            t = t | {wready, awready};
            {awvalid, wvalid} <= {awvalid, wvalid} & ~{awready, wready};
        end
        repeat (2) @(posedge clk);
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    // read one word, ready raised late so the answer must stand
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        {araddr, arvalid} <= {a, 1'b1};
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        @(posedge clk);
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask : rd
endmodule : tpec_host
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the execution controller
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic REF_CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, S_AXI_RREADY;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
    logic [1:0] TASK_RUN, AXIS_MOVE, AXIS_DECEL, AUX_STROBE;
    wire [7:0] pins = {AUX_STROBE, AXIS_DECEL, AXIS_MOVE, TASK_RUN};
    integer n_errors = 0, tests_run = 0, cyc = 0, seed = 44;
    int prog[$];

    tpec_top uut (.REF_CLK, .ARST_N, .S_AXI_AWVALID, .S_AXI_AWREADY,
        .S_AXI_AWADDR, .S_AXI_AWPROT(3'h0), .S_AXI_WVALID, .S_AXI_WREADY,
        .S_AXI_WDATA, .S_AXI_WSTRB(4'hf), .S_AXI_BVALID, .S_AXI_BREADY,
        .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR,
        .S_AXI_ARPROT(3'h0), .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA,
        .S_AXI_RRESP, .TASK_RUN, .AXIS_MOVE, .AXIS_DECEL, .AUX_STROBE);
    tpec_host host (.clk(REF_CLK), .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY), .awaddr(S_AXI_AWADDR),
        .wvalid(S_AXI_WVALID), .wready(S_AXI_WREADY), .wdata(S_AXI_WDATA),
        .bvalid(S_AXI_BVALID), .bready(S_AXI_BREADY), .bresp(S_AXI_BRESP),
        .arvalid(S_AXI_ARVALID), .arready(S_AXI_ARREADY),
        .araddr(S_AXI_ARADDR), .rvalid(S_AXI_RVALID), .rready(S_AXI_RREADY),
        .rdata(S_AXI_RDATA), .rresp(S_AXI_RRESP));

    // clock and cycle ceiling
    always #2.5 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            stop_test();
        end
    end
    // verdict and end of run
    task automatic stop_test;
        if (n_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // write a control word, then leave two ticks for it to be sampled
    task automatic ctl(input logic [7:0] a, input logic [31:0] d);
        host.wr(a, d, resp);
        chk({30'h0, resp}, 32'h0);
        repeat (400) @(posedge REF_CLK);
    endtask : ctl
    // wait a bounded time for one status pin to reach a level
    task automatic wait_pin(input int k, input logic v, input int lim);
        for (int i = 0; i < lim && pins[k] !== v; i++) @(posedge REF_CLK);
        chk({31'h0, pins[k]}, {31'h0, v});
    endtask : wait_pin
    // read a status word and compare the masked fields
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e);
        host.rd(a, rd, resp);
        chk(rd & m, e);
    endtask : rdchk

    // main sequence
    initial begin
        repeat (12) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        @(posedge REF_CLK);
        rdchk(8'h08, 32'h10, 32'h10);
        host.wr(8'h20, $random(seed), resp);
        chk({30'h0, resp}, 32'h2);
        host.rd(8'h20, rd, resp);
        chk({rd[31:2], resp}, 32'h2);
        prog = '{32'h040a | ({$random(seed)} % 4) << 16, 32'h1658};
        foreach (prog[i]) host.wr(8'h40 + 8'(i * 4), prog[i], resp);
        ctl(8'h00, 32'h06);
        wait_pin(0, 1'b1, 400);
        wait_pin(6, 1'b1, 2000);
        repeat (1000) @(posedge REF_CLK);
        rdchk(8'h08, 32'h03ff0f07, 32'h000a0007);
        ctl(8'h00, 32'h46);
        wait_pin(6, 1'b0, 400);
        rdchk(8'h08, 32'h03ff0f01, 32'h1);
        ctl(8'h00, 32'h06);
        wait_pin(0, 1'b0, 4000);
        rdchk(8'h08, 32'h03ff0003, 32'h02580002);
        ctl(8'h00, 32'h40);
        wait_pin(6, 1'b0, 400);
        prog = '{32'h003c0000, 32'h003c1000};
        foreach (prog[i]) host.wr(8'h40 + 8'(i * 4), prog[i], resp);
        ctl(8'h00, 32'h06);
        wait_pin(2, 1'b1, 400);
        ctl(8'h00, 32'h26);
        wait_pin(4, 1'b1, 400);
        wait_pin(0, 1'b0, 4000);
        ctl(8'h00, 32'h22);
        ctl(8'h00, 32'h26);
        chk({31'h0, TASK_RUN[0]}, 32'h0);
        ctl(8'h00, 32'h02);
        ctl(8'h00, 32'h06);
        rdchk(8'h08, 32'h0f01, 32'h0001);
        ctl(8'h00, 32'h36);
        wait_pin(0, 1'b0, 4000);
        ctl(8'h00, 32'h02);
        ctl(8'h00, 32'h06);
        rdchk(8'h08, 32'h0f01, 32'h0101);
        ctl(8'h00, 32'h16);
        wait_pin(0, 1'b0, 4000);
        ctl(8'h00, 32'h12);
        ctl(8'h00, 32'h16);
        chk({31'h0, TASK_RUN[0]}, 32'h0);
        ctl(8'h00, 32'h00);
        ctl(8'h00, 32'h04);
        chk({31'h0, TASK_RUN[0]}, 32'h0);
        host.wr(8'h80, 32'h000a1658, resp);
        ctl(8'h04, 32'h46);
        wait_pin(3, 1'b1, 400);
        wait_pin(1, 1'b0, 4000);
        chk({31'h0, AUX_STROBE[1]}, 32'h0);
        stop_test();
    end
endmodule : tb
`default_nettype wire
